// File: hw/spms_core.sv
// spms_core: byte-wide controller/target serial port with APB registers
`timescale 1ns/10ps
module spms_core (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        sck_i,
	output logic             sck_o,
	output logic             sck_oe,
	input  wire logic        mosi_i,
	output logic             mosi_o,
	output logic             mosi_oe,
	input  wire logic        miso_i,
	output logic             miso_o,
	output logic             miso_oe,
	input  wire logic        ss_n_i,
	output logic             ss_n_o,
	output logic             ss_n_oe,
	input  wire logic        irq_ack,
	output logic             xfer_irq
);
	spms_pkg::spms_ctrl_t  ctrl_ff;
	spms_pkg::spms_pdir_t  pdir_ff;
	spms_pkg::spms_pins_t  pins_ff;
	spms_pkg::spms_pins_t  nxt_pins;
	spms_pkg::spms_state_t state_ff;
	logic [3:0]  pin_sync;
	logic        ss_f;
	logic        sck_f;
	logic        mosi_f;
	logic        miso_f;
	logic        dbl_ff;
	logic [7:0]  shreg_ff;
	logic [7:0]  rxbuf_ff;
	logic [7:0]  sh_next;
	logic [7:0]  rx_val;
	logic        out_bit_ff;
	logic        done_ff;
	logic        write_collision_flag_ff;
	logic [1:0]  arm_ff;
	logic [6:0]  half_cnt_ff;
	logic [6:0]  half;
	logic [3:0]  edge_ff;
	logic        sck_ph_ff;
	logic [2:0]  tgt_cnt_ff;
	logic        sck_prev_ff;
	logic        irq_ff;
	logic [31:0] prdata_ff;
	logic [31:0] nxt_rdata;
	logic        pready_ff;
	logic        pslverr_ff;
	logic        sel_ctrl;
	logic        sel_stat;
	logic        sel_data;
	logic        sel_pdir;
	logic        sel_none;
	logic        acc;
	logic        data_wr;
	logic        data_acc;
	logic        stat_rd;
	logic        ctl_mode;
	logic        ctl_run;
	logic        tgt_act;
	logic        busy;
	logic        load;
	logic        coll;
	logic        ctl_tick;
	logic        ctl_sample;
	logic        ctl_setup;
	logic        ctl_last;
	logic        sck_edge;
	logic        tgt_lead;
	logic        tgt_sample;
	logic        tgt_setup;
	logic        tgt_last;
	logic        sample;
	logic        setup;
	logic        in_bit;
	logic        byte_done;
	logic        clr_done;
	logic        clr_write_collision_flag;

	function automatic logic tx_bit(input logic lsb, input logic [7:0] v);
		tx_bit = lsb ? v[0] : v[7];
	endfunction : tx_bit

	function automatic logic [6:0] half_sel(input logic dbl, input logic [1:0] r);
		case ({dbl, r})
			3'b000:  half_sel = spms_pkg::HALF_D4;
			3'b001:  half_sel = spms_pkg::HALF_D16;
			3'b010:  half_sel = spms_pkg::HALF_D64;
			3'b011:  half_sel = spms_pkg::HALF_D128;
			3'b100:  half_sel = spms_pkg::HALF_D2;
			3'b101:  half_sel = spms_pkg::HALF_D8;
			3'b110:  half_sel = spms_pkg::HALF_D32;
			default: half_sel = spms_pkg::HALF_D64;
		endcase
	endfunction : half_sel

	// all pins cross in; at the fastest rates returning MISO lags the sample edge
	spms_pin_sync #(
		.W       (4),
		.RST_VAL (spms_pkg::SYNC_RST)
	) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.din     ({ss_n_i, sck_i, mosi_i, miso_i}),
		.dout    (pin_sync)
	);

	assign ss_f   = pin_sync[3];
	assign sck_f  = pin_sync[2];
	assign mosi_f = pin_sync[1];
	assign miso_f = pin_sync[0];

	always_comb begin
		sel_ctrl = 1'b0;
		sel_stat = 1'b0;
		sel_data = 1'b0;
		sel_pdir = 1'b0;
		sel_none = 1'b0;
		if (paddr == spms_pkg::ADDR_CTRL) begin
			sel_ctrl = 1'b1;
		end else if (paddr == spms_pkg::ADDR_STAT) begin
			sel_stat = 1'b1;
		end else if (paddr == spms_pkg::ADDR_DATA) begin
			sel_data = 1'b1;
		end else if (paddr == spms_pkg::ADDR_PDIR) begin
			sel_pdir = 1'b1;
		end else begin
			sel_none = 1'b1;
		end
	end

	assign acc      = psel & penable & pready_ff;
	assign data_wr  = acc & pwrite & sel_data;
	assign data_acc = acc & sel_data;
	assign stat_rd  = acc & ~pwrite & sel_stat;

	assign ctl_mode = ctrl_ff.port_enable & ctrl_ff.controller_select;
	assign ctl_run  = (state_ff == spms_pkg::ST_RUN);
	assign tgt_act  = ctrl_ff.port_enable & ~ctrl_ff.controller_select & ~ss_f;
	// target counts as busy once a bit has been taken
	assign busy     = ctl_run | (tgt_act & (tgt_cnt_ff != 3'h0));
	assign load     = data_wr & ~busy;
	assign coll     = data_wr & busy;

	assign half       = half_sel(dbl_ff, ctrl_ff.rate);
	assign ctl_tick   = ctl_run & (half_cnt_ff == half - 7'h01);
	assign ctl_sample = ctl_tick & (edge_ff[0] == ctrl_ff.cpha);
	assign ctl_setup  = ctl_tick & (edge_ff[0] != ctrl_ff.cpha);
	assign ctl_last   = ctl_tick & (edge_ff == spms_pkg::EDGE_LAST);

	assign sck_edge   = tgt_act & (sck_f != sck_prev_ff);
	assign tgt_lead   = sck_f ^ ctrl_ff.cpol;
	assign tgt_sample = sck_edge & (tgt_lead ^ ctrl_ff.cpha);
	assign tgt_setup  = sck_edge & ~(tgt_lead ^ ctrl_ff.cpha);
	assign tgt_last   = tgt_sample & (tgt_cnt_ff == spms_pkg::BIT_LAST);

	assign sample    = ctl_sample | tgt_sample;
	assign setup     = ctl_setup | tgt_setup;
	assign in_bit    = ctl_mode ? miso_f : mosi_f;
	assign byte_done = ctl_last | tgt_last;
	assign sh_next   = ctrl_ff.bit_order ? {in_bit, shreg_ff[7:1]} : {shreg_ff[6:0], in_bit};
	assign rx_val    = sample ? sh_next : shreg_ff;
	assign clr_done  = irq_ack | (arm_ff[1] & data_acc);
	assign clr_write_collision_flag  = arm_ff[0] & data_acc;

	// shared shifter: sent bits leave as received bits enter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shreg_ff <= spms_pkg::BYTE_RST;
		end else if (load) begin
			shreg_ff <= pwdata[7:0];
		end else if (sample) begin
			shreg_ff <= sh_next;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_bit_ff <= 1'b0;
		end else if (load) begin
			out_bit_ff <= tx_bit(ctrl_ff.bit_order, pwdata[7:0]);
		end else if (setup || (!tgt_act && !ctl_run)) begin
			out_bit_ff <= tx_bit(ctrl_ff.bit_order, shreg_ff);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rxbuf_ff <= spms_pkg::BYTE_RST;
		end else if (byte_done) begin
			rxbuf_ff <= rx_val;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= spms_pkg::ST_IDLE;
		end else begin
			case (state_ff)
				spms_pkg::ST_IDLE: begin
					if (load && ctl_mode) begin
						state_ff <= spms_pkg::ST_RUN;
					end
				end
				spms_pkg::ST_RUN: begin
					if (ctl_last || !ctl_mode) begin
						state_ff <= spms_pkg::ST_IDLE;
					end
				end
				default: state_ff <= spms_pkg::ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			half_cnt_ff <= 7'h00;
			edge_ff     <= 4'h0;
			sck_ph_ff   <= 1'b0;
		end else begin
			half_cnt_ff <= (ctl_run && !ctl_tick) ? half_cnt_ff + 7'h01 : 7'h00;
			if (load) begin
				edge_ff <= 4'h0;
			end else if (ctl_tick) begin
				edge_ff <= edge_ff + 4'h1;
			end
			if (!ctl_run || !ctl_mode) begin
				sck_ph_ff <= 1'b0;
			end else if (ctl_tick) begin
				sck_ph_ff <= ~sck_ph_ff;
			end
		end
	end

	// select high restarts the bit count and drops a partial byte
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tgt_cnt_ff  <= 3'h0;
			sck_prev_ff <= spms_pkg::SYNC_RST[2];
		end else begin
			sck_prev_ff <= sck_f;
			if (!tgt_act) begin
				tgt_cnt_ff <= 3'h0;
			end else if (tgt_sample) begin
				tgt_cnt_ff <= tgt_cnt_ff + 3'h1;
			end
		end
	end

	// a new event wins over a clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			done_ff <= 1'b0;
			write_collision_flag_ff <= 1'b0;
			arm_ff  <= 2'b00;
			irq_ff  <= 1'b0;
		end else begin
			done_ff <= byte_done | (done_ff & ~clr_done);
			write_collision_flag_ff <= coll | (write_collision_flag_ff & ~clr_write_collision_flag);
			if (stat_rd) begin
				arm_ff <= {prdata_ff[spms_pkg::STAT_DONE_POS], prdata_ff[spms_pkg::STAT_WRITE_COLLISION_FLAG_POS]};
			end else if (data_acc) begin
				arm_ff <= 2'b00;
			end
			irq_ff <= done_ff & ctrl_ff.irq_en;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_ff <= spms_pkg::CTRL_RST;
			pdir_ff <= spms_pkg::PDIR_RST;
			dbl_ff  <= 1'b0;
		end else if (acc && pwrite) begin
			if (sel_ctrl) begin
				ctrl_ff <= pwdata[7:0];
			end
			if (sel_stat) begin
				dbl_ff <= pwdata[spms_pkg::STAT_DBL_POS];
			end
			if (sel_pdir) begin
				pdir_ff <= pwdata[4:0];
			end
		end
	end

	always_comb begin
		nxt_rdata = 32'h0000_0000;
		if (sel_ctrl) begin
			nxt_rdata[7:0] = ctrl_ff;
		end else if (sel_stat) begin
			nxt_rdata[spms_pkg::STAT_DONE_POS] = done_ff;
			nxt_rdata[spms_pkg::STAT_WRITE_COLLISION_FLAG_POS] = write_collision_flag_ff;
			nxt_rdata[spms_pkg::STAT_DBL_POS]  = dbl_ff;
		end else if (sel_data) begin
			nxt_rdata[7:0] = rxbuf_ff;
		end else if (sel_pdir) begin
			nxt_rdata[4:0] = pdir_ff;
		end
	end

	// one wait state so read data and ready come straight from flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= 32'h0000_0000;
		end else begin
			pready_ff  <= psel & penable & ~pready_ff;
			pslverr_ff <= psel & penable & ~pready_ff & sel_none;
			if (psel && penable && !pready_ff) begin
				prdata_ff <= nxt_rdata;
			end
		end
	end

	always_comb begin
		nxt_pins         = spms_pkg::PINS_RST;
		nxt_pins.sck_o   = ctrl_ff.cpol ^ sck_ph_ff;
		nxt_pins.mosi_o  = out_bit_ff;
		nxt_pins.miso_o  = out_bit_ff;
		nxt_pins.ss_n_o  = pdir_ff.ss_level;
		nxt_pins.sck_oe  = ctl_mode & pdir_ff.sck_dir;
		nxt_pins.mosi_oe = ctl_mode & pdir_ff.mosi_dir;
		nxt_pins.ss_n_oe = ctl_mode & pdir_ff.ss_dir;
		nxt_pins.miso_oe = tgt_act & pdir_ff.miso_dir;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pins_ff <= spms_pkg::PINS_RST;
		end else begin
			pins_ff <= nxt_pins;
		end
	end

	assign prdata   = prdata_ff;
	assign pready   = pready_ff;
	assign pslverr  = pslverr_ff;
	assign sck_o    = pins_ff.sck_o;
	assign sck_oe   = pins_ff.sck_oe;
	assign mosi_o   = pins_ff.mosi_o;
	assign mosi_oe  = pins_ff.mosi_oe;
	assign miso_o   = pins_ff.miso_o;
	assign miso_oe  = pins_ff.miso_oe;
	assign ss_n_o   = pins_ff.ss_n_o;
	assign ss_n_oe  = pins_ff.ss_n_oe;
	assign xfer_irq = irq_ff;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_start_run: assert property (load && ctl_mode |=> state_ff == spms_pkg::ST_RUN)
		else $error("controller write did not start the clock");
	chk_clock_stop: assert property (ctl_last |=> state_ff == spms_pkg::ST_IDLE && done_ff)
		else $error("clock did not stop with done flag");
	chk_irq_raise: assert property (done_ff && ctrl_ff.irq_en |=> xfer_irq)
		else $error("interrupt request missing");
	chk_rx_buffer: assert property (byte_done |=> rxbuf_ff == shreg_ff)
		else $error("receive buffer not updated");
	chk_miso_float: assert property (!ctl_mode && ss_f |=> !miso_oe)
		else $error("miso driven while deselected");
	chk_idle_hold: assert property (!ctrl_ff.controller_select && ss_f && !load
		|=> $stable(shreg_ff))
		else $error("shifter moved while deselected");
	chk_tgt_flag: assert property (tgt_last |=> done_ff)
		else $error("target done flag missing");
	chk_miso_input: assert property (ctl_mode |=> !miso_oe)
		else $error("miso driven in controller mode");
	chk_sck_idle: assert property (state_ff == spms_pkg::ST_IDLE
		|=> sck_o == $past(ctrl_ff.cpol))
		else $error("idle sck level wrong");
	chk_flag_clear: assert property (irq_ack && !byte_done |=> !done_ff)
		else $error("done flag not cleared");
	chk_write_collision_flag_set: assert property (coll && !sample |=> write_collision_flag_ff && $stable(shreg_ff))
		else $error("collision not flagged");

	cov_ctl_byte: cover property (ctl_last);
	cov_tgt_byte: cover property (tgt_last);
	cov_collide: cover property (coll);
	cov_overrun: cover property (byte_done && done_ff);
endmodule : spms_core

// File: hw/spms_pkg.sv
// spms_pkg: constants and types shared by the serial port core
// Function
// - Data goes out on MOSI, in on MISO; both shift registers swap contents.
// - As controller the port never drives select by itself; software owns it.
// - As controller a data write starts the clock and shifts exactly eight bits.
// - After one byte the controller clock stops and the done flag sets.
// - Done flag set with interrupt enable high raises the interrupt request.
// - Last received byte is kept in a receive buffer apart from the shifter.
// - As target with select high the port sleeps and MISO floats.
// - As target data loaded while select high is not shifted until select low.
// - As target the done flag sets as soon as a full byte is shifted.
// - An unread received byte is overwritten when the next byte completes.
// - As target SCK is sampled on the system clock, never used as a clock.
// - When enabled the port overrides pin directions per controller or target.
// - Seven bit rates including clock over two, and LSB or MSB first.
// - Rate bits and double bit pick divider 4,16,64,128 or 2,8,32,64.
// - Polarity sets idle SCK level; phase picks leading or trailing sample.
// - Done flag clears on interrupt service or status read then data access.
// - Data write during a transfer sets collision flag, cleared only by status read then data access.
package spms_pkg;
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STAT = 8'h04;
	localparam logic [7:0] ADDR_DATA = 8'h08;
	localparam logic [7:0] ADDR_PDIR = 8'h0C;

	localparam int STAT_DONE_POS = 7;
	localparam int STAT_WRITE_COLLISION_FLAG_POS = 6;
	localparam int STAT_DBL_POS  = 0;

	localparam logic [7:0] CTRL_RST  = 8'h00;
	localparam logic [4:0] PDIR_RST  = 5'h10;
	localparam logic [7:0] BYTE_RST  = 8'h00;
	localparam logic [3:0] SYNC_RST  = 4'hC;
	localparam logic [2:0] BIT_LAST  = 3'h7;
	localparam logic [3:0] EDGE_LAST = 4'hF;

	// half periods of SCK in system clocks
	localparam logic [6:0] HALF_D2   = 7'h01;
	localparam logic [6:0] HALF_D4   = 7'h02;
	localparam logic [6:0] HALF_D8   = 7'h04;
	localparam logic [6:0] HALF_D16  = 7'h08;
	localparam logic [6:0] HALF_D32  = 7'h10;
	localparam logic [6:0] HALF_D64  = 7'h20;
	localparam logic [6:0] HALF_D128 = 7'h40;
	localparam int SCK_MIN_PHASE_CYC = 2;

	typedef struct packed {
		logic       irq_en;
		logic       port_enable;
		logic       bit_order;
		logic       controller_select;
		logic       cpol;
		logic       cpha;
		logic [1:0] rate;
	} spms_ctrl_t;

	typedef struct packed {
		logic ss_level;
		logic ss_dir;
		logic sck_dir;
		logic miso_dir;
		logic mosi_dir;
	} spms_pdir_t;

	typedef struct packed {
		logic sck_o;
		logic sck_oe;
		logic mosi_o;
		logic mosi_oe;
		logic miso_o;
		logic miso_oe;
		logic ss_n_o;
		logic ss_n_oe;
	} spms_pins_t;

	localparam spms_pins_t PINS_RST = 8'h02;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_RUN  = 2'b10
	} spms_state_t;
endpackage : spms_pkg

// File: hw/spms_pin_sync.sv
// spms_pin_sync: three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module spms_pin_sync #(
	parameter int         W       = 4,
	parameter logic [3:0] RST_VAL = 4'h0
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			logic s1_ff;
			logic s2_ff;
			logic s3_ff;
			logic out_ff;
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					s1_ff  <= RST_VAL[i];
					s2_ff  <= RST_VAL[i];
					s3_ff  <= RST_VAL[i];
					out_ff <= RST_VAL[i];
				end else begin
					s1_ff <= din[i];
					s2_ff <= s1_ff;
					s3_ff <= s2_ff;
					// first stage is never looked at here
					if (s2_ff == s3_ff) begin
						out_ff <= s3_ff;
					end
				end
			end
			assign dout[i] = out_ff;
		end
	endgenerate
endmodule : spms_pin_sync

// File: verif/spms_peer.sv
// spms_peer: behavioural far-side serial device, target or controller role
`timescale 1ns/10ps
module spms_peer (
	input  wire logic       pclk,
	input  wire logic       cpol,
	input  wire logic       cpha,
	input  wire logic       lsb,
	input  wire logic       tgt_en,
	input  wire logic       sck_w,
	input  wire logic       mosi_w,
	input  wire logic       miso_w,
	input  wire logic       ss_n_w,
	output logic            p_sck,
	output logic            p_mosi,
	output logic            p_miso,
	output logic            p_ss_n,
	output logic [7:0]      rx_byte
);
	logic [7:0] t_sh   = 8'h00;
	logic       first  = 1'h1;
	logic       junk   = 1'h0;
	logic       act    = 1'h0;
	logic       sck_q  = 1'h0;
	logic       mosi_q = 1'h0;

	initial begin
		p_ss_n = 1'h1;
		rx_byte = 8'h00;
	end
	// released MOSI and MISO toggle so a stale level never passes for data; released SCK rests at cpol
	always @(posedge pclk) junk <= ~junk;
	assign p_sck  = act ? sck_q : cpol;
	assign p_mosi = act ? mosi_q : junk;
	assign p_miso = (tgt_en && !ss_n_w) ? (lsb ? t_sh[0] : t_sh[7]) : junk;

	task automatic arm(input logic [7:0] b);
		t_sh = b;
		first = 1'h1;
	endtask : arm

	// sample and shift on opposite edges; first setup edge of cpha 1 shows bit 0 already
	always @(sck_w) begin
		if (tgt_en && !ss_n_w) begin
			if ((sck_w != cpol) ^ cpha)
				rx_byte = lsb ? {mosi_w, rx_byte[7:1]} : {rx_byte[6:0], mosi_w};
			else if (first && cpha)
				first = 1'h0;
			else
				t_sh = lsb ? {1'h0, t_sh[7:1]} : {t_sh[6:0], 1'h0};
		end
	end

	task automatic cxfer(input logic [7:0] tx, output logic [7:0] rx);
		int i;
		rx = 8'h00;
		@(posedge pclk);
		act    <= 1'h1;
		sck_q  <= cpol;
		p_ss_n <= 1'h0;
		repeat (12) @(posedge pclk);
		for (i = 0; i < 8; i++) begin
			mosi_q <= lsb ? tx[i] : tx[7 - i];
			if (cpha)
				sck_q <= ~cpol;
			repeat (8) @(posedge pclk);
			rx = lsb ? {miso_w, rx[7:1]} : {rx[6:0], miso_w};
			sck_q <= cpha ? cpol : ~cpol;
			repeat (8) @(posedge pclk);
			if (!cpha)
				sck_q <= cpol;
		end
		p_ss_n <= 1'h1;
		@(posedge pclk);
		act <= 1'h0;
	endtask : cxfer

	task automatic idle_pulses(input int n);
		int i;
		@(posedge pclk);
		sck_q <= cpol;
		act   <= 1'h1;
		for (i = 0; i < 2 * n; i++) begin
			repeat (8) @(posedge pclk);
			sck_q <= ~sck_q;
		end
		repeat (8) @(posedge pclk);
		act <= 1'h0;
	endtask : idle_pulses
endmodule : spms_peer

// File: verif/spms_core_tb_top.sv
// spms_core_tb_top: self-checking bench for the serial port core
`timescale 1ns/10ps
module spms_core_tb_top;
	logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic        irq_ack = 1'h0, cpol = 1'h0, cpha = 1'h0, lsb = 1'h0, tgt_en = 1'h0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rdata;
	logic        pready, pslverr, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe;
	logic        ss_n_o, ss_n_oe, xfer_irq, p_sck, p_mosi, p_miso, p_ss_n;
	logic [7:0]  p_rx, got;
	logic        sck_prev = 1'h0, span_bad = 1'h0, meas = 1'h0;
	int          edges = 0, gap = 0, half = 0, fail_count = 0, n_checks = 0;
	int          seed = 32'hEA98;
	int          hv[8] = '{2, 8, 32, 64, 1, 4, 16, 32};
	logic [64:0] exp_q[$];
	wire         sck_w  = sck_oe ? sck_o : p_sck;
	wire         mosi_w = mosi_oe ? mosi_o : p_mosi;
	wire         miso_w = miso_oe ? miso_o : p_miso;
	wire         ss_n_w = ss_n_oe ? ss_n_o : p_ss_n;

	spms_core uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sck_i(sck_w), .sck_o(sck_o), .sck_oe(sck_oe), .mosi_i(mosi_w),
		.mosi_o(mosi_o), .mosi_oe(mosi_oe), .miso_i(miso_w), .miso_o(miso_o),
		.miso_oe(miso_oe), .ss_n_i(ss_n_w), .ss_n_o(ss_n_o), .ss_n_oe(ss_n_oe),
		.irq_ack(irq_ack), .xfer_irq(xfer_irq));
	spms_peer peer (.pclk(pclk), .cpol(cpol), .cpha(cpha), .lsb(lsb), .tgt_en(tgt_en),
		.sck_w(sck_w), .mosi_w(mosi_w), .miso_w(miso_w), .ss_n_w(ss_n_w), .p_sck(p_sck),
		.p_mosi(p_mosi), .p_miso(p_miso), .p_ss_n(p_ss_n), .rx_byte(p_rx));

	always #5 pclk = ~pclk;

	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : close_out

	task automatic fail_stop(input string what);
		fail_count++;
		$display("ERROR %0t timeout waiting for %s", $time, what);
		close_out();
	endtask : fail_stop

	task automatic cmp_val(input logic [31:0] g, input logic [31:0] e, input string what);
		n_checks++;
		if (g !== e) begin
			fail_count++;
			$display("ERROR %0t %s got %h exp %h", $time, what, g, e);
		end
	endtask : cmp_val

	task automatic cmp_rd(input logic [64:0] e);
		n_checks++;
		if ((prdata & e[63:32]) !== e[31:0] || pslverr !== e[64]) begin
			fail_count++;
			$display("ERROR %0t read got %h/%b exp %h/%b", $time, prdata, pslverr, e[31:0], e[64]);
		end
	endtask : cmp_rd

	// read results are matched here, in order, against the notes left by rd
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'h1 && !pwrite && exp_q.size() > 0)
			cmp_rd(exp_q.pop_front());
		gap <= gap + 1;
		sck_prev <= sck_w;
		if (meas && sck_w !== sck_prev) begin
			edges <= edges + 1;
			gap <= 1;
			if (edges > 0 && gap != half)
				span_bad <= 1'h1;
		end
	end

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel   <= 1'h1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'h1 && n < 50);
		rdata = prdata;
		psel    <= 1'h0;
		penable <= 1'h0;
		if (n >= 50)
			fail_stop("pready");
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'h1, a, d);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
	                  input logic err = 1'h0);
		exp_q.push_back({err, m, e});
		apb(1'h0, a, 32'h0);
	endtask : rd

	task automatic wait_done();
		int n;
		n = 0;
		do begin
			rd(spms_pkg::ADDR_STAT, 32'h0, 32'hFFFF_FF3E);
			n++;
		end while (rdata[spms_pkg::STAT_DONE_POS] !== 1'h1 && n < 600);
		if (n >= 600)
			fail_stop("done flag");
		repeat (2) @(posedge pclk);
	endtask : wait_done

	task automatic mxfer(input logic [7:0] ctrl, input logic dbl, input logic col);
		logic [7:0] tx, ptx;
		tx = 8'($random(seed));
		ptx = 8'($random(seed));
		{lsb, cpol, cpha} = {ctrl[5], ctrl[3], ctrl[2]};
		half = hv[{dbl, ctrl[1:0]}];
		tgt_en = 1'h1;
		wr(spms_pkg::ADDR_STAT, {31'h0, dbl});
		wr(spms_pkg::ADDR_CTRL, {24'h0, ctrl});
		wr(spms_pkg::ADDR_PDIR, 32'h0000_000F);
		peer.arm(ptx);
		edges = 0;
		span_bad = 1'h0;
		meas = 1'h1;
		wr(spms_pkg::ADDR_DATA, {24'h0, tx});
		cmp_val({miso_oe, sck_oe, mosi_oe, ss_n_o}, 32'h6, "controller pins");
		if (col) begin
			wr(spms_pkg::ADDR_DATA, {24'h0, ~tx});
			rd(spms_pkg::ADDR_STAT, 32'h40, 32'hC0);
		end
		wait_done();
		meas = 1'h0;
		cmp_val(edges, 32'h10, "sck edges");
		cmp_val(span_bad, 32'h0, "sck half period");
		cmp_val(sck_w, cpol, "sck idle");
		cmp_val(xfer_irq, ctrl[7], "irq level");
		wr(spms_pkg::ADDR_PDIR, 32'h0000_001F);
		repeat (2) @(posedge pclk);
		cmp_val(ss_n_w, 32'h1, "select released");
		cmp_val(p_rx, tx, "peer rx");
		// returned bits cross the pin filter: under eight clocks a half they may be stale
		if (half >= 8)
			rd(spms_pkg::ADDR_DATA, {24'h0, ptx}, 32'hFFFF_FFFF);
		else
			rd(spms_pkg::ADDR_DATA, 32'h0, 32'hFFFF_FF00);
		rd(spms_pkg::ADDR_STAT, {31'h0, dbl}, 32'hFFFF_FFFF);
		cmp_val(xfer_irq, 32'h0, "irq after clear");
	endtask : mxfer

	initial begin
		int k;
		repeat (8) @(posedge pclk);
		cmp_val({sck_oe, mosi_oe, miso_oe, ss_n_oe, xfer_irq}, 32'h0, "reset pins");
		presetn <= 1'h1;
		rd(spms_pkg::ADDR_CTRL, spms_pkg::CTRL_RST, 32'hFFFF_FFFF);
		rd(spms_pkg::ADDR_STAT, 32'h0, 32'hFFFF_FFFF);
		rd(spms_pkg::ADDR_DATA, spms_pkg::BYTE_RST, 32'hFFFF_FFFF);
		rd(spms_pkg::ADDR_PDIR, spms_pkg::PDIR_RST, 32'hFFFF_FFFF);
		wr(8'h14, 32'hFFFF_FFFF);
		rd(8'h14, 32'h0, 32'hFFFF_FFFF, 1'h1);
		rd(spms_pkg::ADDR_CTRL, 32'h0, 32'hFFFF_FFFF);
		for (k = 0; k < 8; k++)
			mxfer({2'h1, k[0], 1'h1, k[1], k[2], k[1:0]}, k[2], 1'h0);
		for (k = 0; k < 4; k++)
			mxfer({2'h3, k[0], 1'h1, k[1:0], 2'h1}, 1'h0, k[1]);
		wr(spms_pkg::ADDR_DATA, 32'h0000_00A5);
		wait_done();
		cmp_val(xfer_irq, 32'h1, "irq raised");
		irq_ack <= 1'h1;
		@(posedge pclk);
		irq_ack <= 1'h0;
		repeat (2) @(posedge pclk);
		cmp_val(xfer_irq, 32'h0, "irq ack");
		rd(spms_pkg::ADDR_STAT, 32'h0, 32'h80);
		{lsb, cpol, cpha} = 3'h5;
		tgt_en = 1'h0;
		wr(spms_pkg::ADDR_CTRL, 32'h0000_00E4);
		wr(spms_pkg::ADDR_DATA, 32'h0000_003C);
		peer.idle_pulses(4);
		cmp_val({sck_oe, mosi_oe, ss_n_oe, miso_oe}, 32'h0, "target idle pins");
		peer.cxfer(8'hC3, got);
		cmp_val(got, 32'h3C, "target tx");
		cmp_val(xfer_irq, 32'h1, "target irq");
		rd(spms_pkg::ADDR_STAT, 32'h80, 32'h80);
		wr(spms_pkg::ADDR_DATA, 32'h0000_0096);
		peer.cxfer(8'h69, got);
		cmp_val(got, 32'h96, "target next tx");
		rd(spms_pkg::ADDR_DATA, 32'h69, 32'hFFFF_FFFF);
		close_out();
	end
endmodule : spms_core_tb_top
